// >>> pkg/ddr_wr_pkg.sv
// shared constants and types for the write-burst controller and memory ends
`default_nettype none
package ddr_wr_pkg;
  // ----------------------------------------
  // clocking and timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int CK_DIV        = 16;
  localparam int CK_PERIOD_NS  = CLK_PERIOD_NS * CK_DIV;
  localparam int T_WR_NS       = 15;
  localparam int T_WTR_NS      = 10;
  localparam int WR_CK         = (T_WR_NS + CK_PERIOD_NS - 1) / CK_PERIOD_NS;
  localparam int WTR_MIN_CK    = 2;
  localparam int WTR_RAW_CK    = (T_WTR_NS + CK_PERIOD_NS - 1) / CK_PERIOD_NS;
  localparam int WTR_CK        = (WTR_RAW_CK > WTR_MIN_CK) ? WTR_RAW_CK : WTR_MIN_CK;
  localparam logic [3:0] PH_CMD  = 4'h8;
  localparam logic [3:0] PH_DQ_R = 4'hc;
  localparam logic [3:0] PH_DQ_F = 4'h4;
  localparam logic [3:0] CK_HALF = 4'h8;
  // ----------------------------------------
  // link widths
  // ----------------------------------------
  localparam int BA_W  = 3;
  localparam int A_W   = 14;
  localparam int DQ_W  = 16;
  localparam int NLANE = 2;
  localparam int BANKS = 8;
  localparam int COL_W = 6;
  localparam int SCH   = 16;
  // ----------------------------------------
  // apb register map
  // ----------------------------------------
  localparam int APB_AW = 8;
  localparam logic [7:0] MODE_OFS  = 8'h00;
  localparam logic [7:0] CMD_OFS   = 8'h04;
  localparam logic [7:0] WDATA_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS  = 8'h0c;
  localparam int MODE_CL_LSB  = 0;
  localparam int MODE_BL8_BIT = 3;
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_BA_LSB   = 2;
  localparam int CMD_A_LSB    = 16;
  localparam logic [2:0] CL_RST  = 3'h3;
  localparam logic       BL8_RST = 1'b0;
  // ----------------------------------------
  // mode register fields and commands
  // ----------------------------------------
  localparam int MR_BL_LSB = 0;
  localparam int MR_CL_LSB = 4;
  localparam int MR_WR_LSB = 9;
  localparam int AP_BIT    = 10;
  localparam logic [2:0] BL4_CODE = 3'h2;
  localparam logic [2:0] BL8_CODE = 3'h3;
  localparam logic [2:0] CMD_NOP  = 3'h7;
  localparam logic [2:0] CMD_ACT  = 3'h3;
  localparam logic [2:0] CMD_RD   = 3'h5;
  localparam logic [2:0] CMD_WR   = 3'h4;
  localparam logic [2:0] CMD_PRE  = 3'h2;
  localparam logic [2:0] CMD_LMR  = 3'h0;
  typedef enum logic [1:0] {OP_WRITE, OP_READ, OP_PRE, OP_ACT} op_t;
endpackage : ddr_wr_pkg
`default_nettype wire

// >>> pkg/ddr_if.sv
// link between the controller end and the memory end, with pin resolution
`default_nettype none
interface ddr_if;
  import ddr_wr_pkg::*;
  logic                ck;
  logic                cke;
  logic                cs_n;
  logic                ras_n;
  logic                cas_n;
  logic                we_n;
  logic [BA_W-1:0]     ba;
  logic [A_W-1:0]      addr;
  logic [DQ_W-1:0]     dq_o;
  logic                dq_oe_n;
  logic [NLANE-1:0]    dqs_o;
  logic [NLANE-1:0]    dqs_oe_n;
  logic [NLANE-1:0]    dm;
  logic [DQ_W-1:0]     mdq_o;
  logic                mdq_oe_n;
  logic [DQ_W-1:0]     dq_w;
  logic [NLANE-1:0]    dqs_w;
  // an undriven strobe reads low so that no false rising edge appears
  assign dq_w  = !dq_oe_n ? dq_o : (!mdq_oe_n ? mdq_o : '0);
  assign dqs_w = dqs_o & ~dqs_oe_n;
  modport ctl (output ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr,
               output dq_o, dq_oe_n, dqs_o, dqs_oe_n, dm);
  modport mem (input ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr,
               input dq_w, dqs_w, dm, output mdq_o, mdq_oe_n);
endinterface : ddr_if
`default_nettype wire

// >>> logic/ck_timer.sv
// loadable down counter of link-clock cycles; a load only ever extends it
`default_nettype none
module ck_timer #(
  parameter int W = 5
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         tick,
  input  wire logic         load,
  input  wire logic [W-1:0] val,
  output logic              busy
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= (val > cnt_q) ? val : cnt_q;
    end else if (tick && cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign busy = (cnt_q != '0);
endmodule : ck_timer
`default_nettype wire

// >>> logic/ddr_wr_ctl.sv
// controller end: apb command registers, spacing timers, command and write data pins
//
// Design decisions made here: the APB register port and the address map.
`default_nettype none
// Functional notes
// - write latency is read latency minus one
// - write carries bank, column, precharge choice
// - address bit ten high selects auto-precharge
// - memory takes data on strobe edges
// - strobe held low for preamble and postamble
// - first strobe rise at write latency
// - memory ignores data after burst ends
// - gapless writes spaced half a burst
// - length-four writes never interrupted
// - length-eight truncated only by aligned write
// - interrupting write exactly two clocks later
// - interrupted precharge waits full burst recovery
// - write-to-read at least two clocks
// - write-to-read counted after last data pair
// - write-to-read applies within same device
// - same-bank precharge waits write recovery
// - other-bank precharge needs no recovery wait
// - concurrent auto-precharge spacing to other banks
// - recovery setting programmed in mode bits 9-11
// - each byte strobe times its own byte
// - clock enable stays high through writes
module ddr_wr_ctl (
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  input  wire logic [ddr_wr_pkg::APB_AW-1:0] paddr,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  ddr_if.ctl                                 ddr
);
  import ddr_wr_pkg::*;

  // ----------------------------------------
  // link clock divider
  // ----------------------------------------
  logic [3:0] cnt_q;
  logic       tick_rise;
  logic       tick_cmd;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // slots advance one clk before the link clock rises, so the strobe switches with it and data hold steady across it
  assign tick_rise = (cnt_q == 4'hf);
  assign tick_cmd  = (cnt_q == PH_CMD);

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  logic [2:0]      cl_q;
  logic            bl8_q;
  logic            mpend_q;
  logic            pend_q;
  op_t             op_q;
  logic [BA_W-1:0] ba_q;
  logic [A_W-1:0]  a_q;
  logic [15:0]     wdata_q;
  logic            setup;
  logic            wr_acc;
  logic            hit;
  logic [31:0]     rd_val;
  logic [BANKS-1:0] bank_busy;
  logic            ww_busy;
  logic            wtr_busy;
  logic            burst_busy;
  logic            issue_cmd;
  logic            issue_lmr;

  assign setup  = psel && !penable;
  assign wr_acc = psel && penable && pready && pwrite;
  assign hit    = (paddr == MODE_OFS) || (paddr == CMD_OFS) ||
                  (paddr == WDATA_OFS) || (paddr == STAT_OFS);

  always_comb begin
    rd_val = '0;
    if (paddr == MODE_OFS) begin
      rd_val[MODE_CL_LSB +: 3] = cl_q;
      rd_val[MODE_BL8_BIT]     = bl8_q;
    end else if (paddr == CMD_OFS) begin
      rd_val[CMD_OP_LSB +: 2]   = op_q;
      rd_val[CMD_BA_LSB +: BA_W] = ba_q;
      rd_val[CMD_A_LSB +: A_W]   = a_q;
    end else if (paddr == WDATA_OFS) begin
      rd_val[15:0] = wdata_q;
    end else if (paddr == STAT_OFS) begin
      rd_val[0]    = pend_q;
      rd_val[1]    = burst_busy;
      rd_val[2]    = wtr_busy;
      rd_val[3]    = mpend_q;
      rd_val[15:8] = bank_busy;
    end
  end

  // answer in the first access cycle; no wait states
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !hit;
      if (setup) begin
        prdata <= pwrite ? 32'h0 : rd_val;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cl_q    <= CL_RST;
      bl8_q   <= BL8_RST;
      mpend_q <= 1'b0;
    end else if (wr_acc && paddr == MODE_OFS) begin
      cl_q    <= pwdata[MODE_CL_LSB +: 3];
      bl8_q   <= pwdata[MODE_BL8_BIT];
      mpend_q <= 1'b1;
    end else if (issue_lmr) begin
      mpend_q <= 1'b0;
    end
  end

  // a command written while one is still pending is dropped; status bit 0 shows it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_q <= 1'b0;
      op_q   <= OP_WRITE;
      ba_q   <= '0;
      a_q    <= '0;
    end else if (wr_acc && paddr == CMD_OFS && !pend_q) begin
      pend_q <= 1'b1;
      op_q   <= op_t'(pwdata[CMD_OP_LSB +: 2]);
      ba_q   <= pwdata[CMD_BA_LSB +: BA_W];
      a_q    <= pwdata[CMD_A_LSB +: A_W];
    end else if (issue_cmd) begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wdata_q <= '0;
    end else if (wr_acc && paddr == WDATA_OFS) begin
      wdata_q <= pwdata[15:0];
    end
  end

  // ----------------------------------------
  // spacing timers
  // ----------------------------------------
  logic [2:0] wl;
  logic [2:0] half;
  logic [4:0] t_wr_v;
  logic [4:0] t_wtr_v;
  logic [4:0] t_ww_v;
  logic       is_wr;
  logic       cmd_ok;

  assign wl      = cl_q - 3'h1;
  assign half    = bl8_q ? 3'h4 : 3'h2;
  assign is_wr   = issue_cmd && op_q == OP_WRITE;
  assign t_wr_v  = 5'(wl) + 5'(half) + 5'(WR_CK) - 5'h1;
  assign t_wtr_v = 5'(wl) + 5'(half) + 5'(WTR_CK) - 5'h1;
  assign t_ww_v  = 5'(half) - 5'h1;

  for (genvar b = 0; b < BANKS; b++) begin : g_bank
    ck_timer #(.W(5)) u_wr (
      .clk     (clk),
      .sys_rst (sys_rst),
      .tick    (tick_cmd),
      .load    (is_wr && ba_q == BA_W'(b)),
      .val     (t_wr_v),
      .busy    (bank_busy[b])
    );
  end

  ck_timer #(.W(5)) u_ww (
    .clk     (clk),
    .sys_rst (sys_rst),
    .tick    (tick_cmd),
    .load    (is_wr),
    .val     (t_ww_v),
    .busy    (ww_busy)
  );

  ck_timer #(.W(5)) u_wtr (
    .clk     (clk),
    .sys_rst (sys_rst),
    .tick    (tick_cmd),
    .load    (is_wr),
    .val     (t_wtr_v),
    .busy    (wtr_busy)
  );

  always_comb begin
    unique case (op_q)
      OP_WRITE: cmd_ok = !ww_busy;
      OP_READ:  cmd_ok = !wtr_busy;
      OP_PRE:   cmd_ok = a_q[AP_BIT] ? ~|bank_busy : !bank_busy[ba_q];
      OP_ACT:   cmd_ok = !bank_busy[ba_q];
    endcase
  end

  assign issue_lmr = tick_cmd && mpend_q && !burst_busy && ~|bank_busy && !wtr_busy;
  assign issue_cmd = tick_cmd && pend_q && !mpend_q && cmd_ok;

  // ----------------------------------------
  // command pins
  // ----------------------------------------
  logic [2:0]     code;
  logic [A_W-1:0] mr_val;

  always_comb begin
    unique case (op_q)
      OP_WRITE: code = CMD_WR;
      OP_READ:  code = CMD_RD;
      OP_PRE:   code = CMD_PRE;
      OP_ACT:   code = CMD_ACT;
    endcase
  end

  assign mr_val = (A_W'(bl8_q ? BL8_CODE : BL4_CODE) << MR_BL_LSB) |
                  (A_W'(cl_q) << MR_CL_LSB) |
                  (A_W'(WR_CK - 1) << MR_WR_LSB);

  // commands change at the link clock's falling edge so they are stable at its rise
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ddr.cke                          <= 1'b0;
      ddr.cs_n                         <= 1'b1;
      {ddr.ras_n, ddr.cas_n, ddr.we_n} <= CMD_NOP;
      ddr.ba                           <= '0;
      ddr.addr                         <= '0;
    end else begin
      ddr.cke  <= 1'b1;
      ddr.cs_n <= 1'b0;
      if (tick_cmd) begin
        if (issue_lmr) begin
          {ddr.ras_n, ddr.cas_n, ddr.we_n} <= CMD_LMR;
          ddr.ba                           <= '0;
          ddr.addr                         <= mr_val;
        end else if (issue_cmd) begin
          {ddr.ras_n, ddr.cas_n, ddr.we_n} <= code;
          ddr.ba                           <= ba_q;
          ddr.addr                         <= a_q;
        end else begin
          {ddr.ras_n, ddr.cas_n, ddr.we_n} <= CMD_NOP;
        end
      end
    end
  end

  // ----------------------------------------
  // write data schedule, one slot per link clock cycle
  // ----------------------------------------
  logic [SCH-1:0] vld_q;
  logic [15:0]    sd_q [SCH];
  logic           was_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      vld_q <= '0;
      was_q <= 1'b0;
      for (int i = 0; i < SCH; i++) begin
        sd_q[i] <= '0;
      end
    end else if (tick_rise) begin
      was_q <= vld_q[0];
      vld_q <= vld_q >> 1;
      for (int i = 0; i < SCH - 1; i++) begin
        sd_q[i] <= sd_q[i+1];
      end
    end else if (is_wr) begin
      for (int j = 0; j < 4; j++) begin
        if (j < int'(half)) begin
          vld_q[int'(wl) + 1 + j] <= 1'b1;
          sd_q[int'(wl) + 1 + j]  <= wdata_q + 16'(2 * j);
        end
      end
    end
  end

  assign burst_busy = (|vld_q) || was_q;

  // ----------------------------------------
  // strobe and data pins
  // ----------------------------------------
  logic dqs_drv;
  logic dqs_val;
  logic dq_drv;
  logic [15:0] dq_val;

  always_comb begin
    dqs_drv = vld_q[0] || (vld_q[1] && cnt_q >= CK_HALF) ||
              (was_q && !vld_q[0] && cnt_q < CK_HALF);
    dqs_val = vld_q[0] && cnt_q < CK_HALF;
    dq_drv  = 1'b1;
    dq_val  = '0;
    if (cnt_q >= PH_DQ_R && vld_q[1]) begin
      dq_val = sd_q[1];
    end else if (cnt_q < PH_DQ_F && vld_q[0]) begin
      dq_val = sd_q[0];
    end else if (cnt_q >= PH_DQ_F && cnt_q < PH_DQ_R && vld_q[0]) begin
      dq_val = sd_q[0] + 16'h1;
    end else begin
      dq_drv = 1'b0;
    end
  end

  // every pin, the link clock included, is registered once so phases stay aligned
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ddr.ck       <= 1'b0;
      ddr.dqs_o    <= '0;
      ddr.dqs_oe_n <= '1;
      ddr.dq_o     <= '0;
      ddr.dq_oe_n  <= 1'b1;
      ddr.dm       <= '0;
    end else begin
      ddr.ck       <= (cnt_q < CK_HALF);
      ddr.dqs_o    <= {NLANE{dqs_val}};
      ddr.dqs_oe_n <= {NLANE{!dqs_drv}};
      ddr.dq_o     <= dq_val;
      ddr.dq_oe_n  <= !dq_drv;
      ddr.dm       <= '0;
    end
  end
endmodule : ddr_wr_ctl
`default_nettype wire

// >>> logic/ddr_wr_mem.sv
// memory end: samples the link, decodes commands, captures write bursts per byte lane
`default_nettype none
module ddr_wr_mem (
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  ddr_if.mem                                 ddr,
  input  wire logic [ddr_wr_pkg::BA_W-1:0]   peek_bank,
  input  wire logic [ddr_wr_pkg::COL_W-1:0]  peek_col,
  output wire logic [ddr_wr_pkg::DQ_W-1:0]   peek_data,
  output logic      [ddr_wr_pkg::BANKS-1:0]  bank_open,
  output logic      [2:0]                    mode_cl,
  output logic                               mode_bl8
);
  import ddr_wr_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  localparam int SW = 6 + BA_W + A_W + DQ_W + 2 * NLANE;
  logic [SW-1:0]    s1_q;
  logic [SW-1:0]    s2_q;
  logic             ck3_q;
  logic [NLANE-1:0] dqs3_q;
  logic ck_s, cke_s, cs_s, ras_s, cas_s, we_s;
  logic [BA_W-1:0]  ba_s;
  logic [A_W-1:0]   a_s;
  logic [DQ_W-1:0]  dq_s;
  logic [NLANE-1:0] dqs_s;
  logic [NLANE-1:0] dm_s;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q   <= '0;
      s2_q   <= '0;
      ck3_q  <= 1'b0;
      dqs3_q <= '0;
    end else begin
      s1_q   <= {ddr.ck, ddr.cke, ddr.cs_n, ddr.ras_n, ddr.cas_n, ddr.we_n,
                 ddr.ba, ddr.addr, ddr.dq_w, ddr.dqs_w, ddr.dm};
      s2_q   <= s1_q;
      ck3_q  <= ck_s;
      dqs3_q <= dqs_s;
    end
  end

  assign {ck_s, cke_s, cs_s, ras_s, cas_s, we_s, ba_s, a_s, dq_s, dqs_s, dm_s} = s2_q;

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  logic       cmd_v;
  logic [2:0] code;
  logic       wr_cmd;
  logic [2:0] wr_q;
  logic [1:0] since_q;
  logic       trunc_ok_q;
  logic [1:0] wptr_q;
  logic [BA_W-1:0]  q_ba  [4];
  logic [COL_W-1:0] q_col [4];
  logic [3:0]       q_len [4];

  assign cmd_v  = ck_s && !ck3_q && cke_s && !cs_s;
  assign code   = {ras_s, cas_s, we_s};
  assign wr_cmd = cmd_v && code == CMD_WR;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_cl  <= CL_RST;
      mode_bl8 <= BL8_RST;
      wr_q     <= 3'h1;
    end else if (cmd_v && code == CMD_LMR && ba_s == '0) begin
      mode_cl  <= a_s[MR_CL_LSB +: 3];
      mode_bl8 <= (a_s[MR_BL_LSB +: 3] == BL8_CODE);
      wr_q     <= a_s[MR_WR_LSB +: 3] + 3'h1;
    end
  end

  // a write two link cycles after an open-row length-eight write cuts it to four
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      since_q    <= 2'h3;
      trunc_ok_q <= 1'b0;
      wptr_q     <= '0;
      for (int i = 0; i < 4; i++) begin
        q_ba[i]  <= '0;
        q_col[i] <= '0;
        q_len[i] <= '0;
      end
    end else if (wr_cmd) begin
      since_q        <= 2'h0;
      trunc_ok_q     <= mode_bl8 && !a_s[AP_BIT];
      q_ba[wptr_q]   <= ba_s;
      q_col[wptr_q]  <= a_s[COL_W-1:0];
      q_len[wptr_q]  <= mode_bl8 ? 4'h8 : 4'h4;
      wptr_q         <= wptr_q + 2'h1;
      if (since_q == 2'h1 && trunc_ok_q) begin
        q_len[wptr_q - 2'h1] <= 4'h4;
      end
    end else if (ck_s && !ck3_q && since_q != 2'h3) begin
      since_q <= since_q + 2'h1;
    end
  end

  // ----------------------------------------
  // auto-precharge and open rows
  // ----------------------------------------
  logic [4:0]       ap_v;
  logic [BANKS-1:0] ap_busy;
  logic [BANKS-1:0] ap_prev_q;

  assign ap_v = 5'(mode_cl - 3'h1) + (mode_bl8 ? 5'h4 : 5'h2) + 5'(wr_q);

  for (genvar b = 0; b < BANKS; b++) begin : g_bank
    ck_timer #(.W(5)) u_ap (
      .clk     (clk),
      .sys_rst (sys_rst),
      .tick    (ck_s && !ck3_q),
      .load    (wr_cmd && a_s[AP_BIT] && ba_s == BA_W'(b)),
      .val     (ap_v),
      .busy    (ap_busy[b])
    );
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ap_prev_q <= '0;
      bank_open <= '0;
    end else begin
      ap_prev_q <= ap_busy;
      for (int b = 0; b < BANKS; b++) begin
        if (ap_prev_q[b] && !ap_busy[b]) begin
          bank_open[b] <= 1'b0;
        end else if (cmd_v && code == CMD_ACT && ba_s == BA_W'(b)) begin
          bank_open[b] <= 1'b1;
        end else if (cmd_v && code == CMD_PRE && (a_s[AP_BIT] || ba_s == BA_W'(b))) begin
          bank_open[b] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // data capture, each lane on its own strobe
  // ----------------------------------------
  for (genvar l = 0; l < NLANE; l++) begin : g_lane
    logic [1:0] rp_q;
    logic [3:0] idx_q;
    logic       st_q;
    logic [7:0] pk_q;
    logic [7:0] mem_q [BANKS * (2 ** COL_W)];
    logic       rise;
    logic       take;

    assign rise = dqs_s[l] && !dqs3_q[l];
    // the first element must land on a rising edge; an empty queue ignores data
    assign take = (rp_q != wptr_q) && (rise || (st_q && !dqs_s[l] && dqs3_q[l]));

    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        rp_q  <= '0;
        idx_q <= '0;
        st_q  <= 1'b0;
      end else if (take) begin
        if (idx_q == q_len[rp_q] - 4'h1) begin
          idx_q <= '0;
          rp_q  <= rp_q + 2'h1;
          st_q  <= 1'b0;
        end else begin
          idx_q <= idx_q + 4'h1;
          st_q  <= 1'b1;
        end
      end
    end

    always_ff @(posedge clk) begin
      if (take && !dm_s[l]) begin
        mem_q[{q_ba[rp_q], q_col[rp_q] + COL_W'(idx_q)}] <= dq_s[8*l +: 8];
      end
      pk_q <= mem_q[{peek_bank, peek_col}];
    end

    assign peek_data[8*l +: 8] = pk_q;
  end

  // the memory never drives data during writes; its pins stay released
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ddr.mdq_o    <= '0;
      ddr.mdq_oe_n <= 1'b1;
    end else begin
      ddr.mdq_o    <= '0;
      ddr.mdq_oe_n <= 1'b1;
    end
  end
endmodule : ddr_wr_mem
`default_nettype wire

// >>> logic/ddr_wr_pad_unused.sv
// holds no logic; every module of the block lives in its own file
`default_nettype none
`default_nettype wire

// >>> verification/ddr_wr_chk.sv
// link checker for the write-burst ends
`default_nettype none
module ddr_wr_chk (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       ck,
  input wire logic       cke,
  input wire logic       cs_n,
  input wire logic       ras_n,
  input wire logic       cas_n,
  input wire logic       we_n,
  input wire logic       dq_oe_n,
  input wire logic [1:0] dqs_oe_n,
  input wire logic [1:0] dqs_w
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  wire logic wr = !cs_n && ras_n && !cas_n && !we_n;
  // ------
  // properties
  // ------
  property p_cke; $past(cke) |-> cke; endproperty
  a_cke: assert property (p_cke) else $error("cke fell");
  property p_pre; $fell(dqs_oe_n[0]) |-> !dqs_w[0]; endproperty
  a_pre: assert property (p_pre) else $error("no preamble");
  property p_post; $rose(dqs_oe_n[0]) |-> !$past(dqs_w[0]); endproperty
  a_post: assert property (p_post) else $error("no postamble");
  property p_lane; dqs_w[0] == dqs_w[1]; endproperty
  a_lane: assert property (p_lane) else $error("lanes differ");
  property p_idle; $rose(dqs_oe_n[0]) |-> ##[0:8] dq_oe_n; endproperty
  a_idle: assert property (p_idle) else $error("dq still driven");
  property p_half; $rose(ck) |-> ck [*8] ##1 !ck; endproperty
  a_half: assert property (p_half) else $error("ck phase length");
  property p_align; $rose(dqs_w[0]) |-> ##[0:4] ck; endproperty
  a_align: assert property (p_align) else $error("strobe off clock");
  // wl of two link clocks plus the half period before registration
  property p_wl; $rose(wr) |-> ##[36:44] $rose(dqs_w[0]); endproperty
  a_wl: assert property (p_wl) else $error("write latency");
  // clk cycles since the last write command, saturating
  logic       wr_q;
  logic [5:0] gap_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_q  <= 1'b0;
      gap_q <= 6'h3f;
    end else begin
      wr_q <= wr;
      if (wr && !wr_q) begin
        gap_q <= 6'h0;
      end else if (gap_q != 6'h3f) begin
        gap_q <= gap_q + 6'h1;
      end
    end
  end
  // two link clocks at least between writes, so no length-four burst is ever cut short
  property p_gap; $rose(wr) |-> gap_q >= 6'h1f; endproperty
  a_gap: assert property (p_gap) else $error("write too soon");
  c_wr: cover property ($rose(wr));
  c_lane: cover property ($rose(dqs_w[1]));
  c_act: cover property ($fell(ras_n) && cas_n);
endmodule : ddr_wr_chk
`default_nettype wire

// >>> verification/test_sdram_write_burst_timing.sv
// bench: apb-driven writes checked through the memory end
`default_nettype none
module test_sdram_write_burst_timing;
  timeunit 1ns;
  timeprecision 1ps;
  import ddr_wr_pkg::*;
  localparam logic [15:0] BASE = 16'h5a30;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  paddr = 8'h0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [2:0]  peek_bank = 3'h0;
  logic [5:0]  peek_col = 6'h0;
  logic [31:0] prdata, rdat;
  logic        pready, pslverr, rerr, mode_bl8;
  logic [15:0] peek_data;
  logic [7:0]  bank_open;
  logic [2:0]  mode_cl;
  int          errors = 0;
  int          checks_done = 0;
  ddr_if link ();
  ddr_wr_ctl ddr_wr_ctl_i (.clk, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .ddr(link));
  ddr_wr_mem ddr_wr_mem_i (.clk, .sys_rst, .ddr(link), .peek_bank, .peek_col,
    .peek_data, .bank_open, .mode_cl, .mode_bl8);
  ddr_wr_chk ddr_wr_chk_i (.clk, .sys_rst, .ck(link.ck), .cke(link.cke),
    .cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n),
    .dq_oe_n(link.dq_oe_n), .dqs_oe_n(link.dqs_oe_n), .dqs_w(link.dqs_w));
  always #5 clk = ~clk;
  // ------
  // tasks
  // ------
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      errors++;
      close_out();
    end
  endtask : apb
  // poll status until the masked busy bits clear
  task automatic settle(input logic [15:0] m);
    int n;
    for (n = 0; n < 300; n++) begin
      apb(1'b0, STAT_OFS, 32'h0);
      if ((rdat[15:0] & m) === 16'h0) break;
    end
    if (n == 300) begin
      errors++;
      close_out();
    end
  endtask : settle
  // a command written while one is pending is dropped, so wait first
  task automatic cmd(input op_t op, input logic [2:0] b, input logic [13:0] a);
    settle(16'h0001);
    apb(1'b1, CMD_OFS, {2'b0, a, 11'b0, b, op});
  endtask : cmd
  task automatic burst(input logic [2:0] b, input logic [5:0] c, input int bl);
    for (int k = 0; k < bl; k++) begin
      @(posedge clk);
      peek_bank <= b;
      peek_col <= c + 6'(k);
      repeat (2) @(posedge clk);
      chk(32'(peek_data), 32'(BASE + 16'(k)));
    end
  endtask : burst
  initial begin
    int n;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    apb(1'b0, MODE_OFS, 32'h0);
    chk(rdat & 32'hf, {28'h0, BL8_RST, CL_RST});
    apb(1'b0, 8'h10, 32'h0);
    chk(32'(rerr), 32'h1);
    $display("reset and map done");
    apb(1'b1, WDATA_OFS, 32'(BASE));
    cmd(OP_ACT, 3'h1, 14'h0);
    cmd(OP_ACT, 3'h2, 14'h0);
    cmd(OP_WRITE, 3'h1, 14'h000);
    cmd(OP_WRITE, 3'h2, 14'h008);
    settle(16'hffff);
    burst(3'h1, 6'h00, 4);
    burst(3'h2, 6'h08, 4);
    chk(32'(bank_open[2:1]), 32'h3);
    $display("gapless writes done");
    cmd(OP_WRITE, 3'h1, 14'h410);
    settle(16'hffff);
    for (n = 0; n < 200 && bank_open[1] !== 1'b0; n++) @(posedge clk);
    chk(32'(bank_open[2:1]), 32'h2);
    burst(3'h1, 6'h10, 4);
    $display("auto-precharge write done");
    apb(1'b1, MODE_OFS, 32'h0000000b);
    cmd(OP_WRITE, 3'h2, 14'h020);
    cmd(OP_PRE, 3'h1, 14'h000);
    cmd(OP_READ, 3'h2, 14'h020);
    cmd(OP_PRE, 3'h2, 14'h000);
    settle(16'hffff);
    for (n = 0; n < 200 && bank_open[2] !== 1'b0; n++) @(posedge clk);
    chk(32'(bank_open), 32'h0);
    burst(3'h2, 6'h20, 8);
    chk(32'({mode_bl8, mode_cl}), 32'hb);
    $display("length-eight write done");
    close_out();
  end
endmodule : test_sdram_write_burst_timing
`default_nettype wire
